// *** ebwb_ctrl.v ***
// Functional notes
// - extended select maps program wait fields
// - bits 14-12 set io wait count
// - bits 11-9 set upper data waits
// - bits 8-6 set lower data waits
// - bits 5-3 set upper program waits
// - bits 2-0 set lower program waits
// - reset: all fields seven, select zero
// - multiplier bit doubles wait counts
// - control bits 15-1 ignore writes
// - add one cycle on bank crossing
// - consecutive mode: every read adds a start and a trailing cycle
// - clock output divided by field plus one, by two for field zero
// - suppress bit gates interrupt acknowledge output
// - host keeper bit, or wide mode pin
// - data keeper bit holds data bus
// - wait ranges register at 0028h
// - bank change withholds strobe one cycle
`include "ebwb_defines.vh"
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------
// external bus wait and bank controller
//------------------------------------------------
// one access at a time; the core holds off while busy
module ebwb_ctrl
(
    // clock and reset
    input wire clk,
    input wire resetn,
    // core register port
    input wire reg_wr,
    input wire [15:0] reg_addr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata_q,
    // core access request
    input wire acc_req,
    input wire acc_read,
    input wire [1:0] acc_space,
    input wire [22:0] acc_addr,
    output reg acc_busy_q,
    output reg acc_done_q,
    // external bus
    input wire ext_ready,
    output reg memory_strobe_n_q,
    output reg [22:0] ext_addr_q,
    output reg clock_output_pin_q,
    // interrupt acknowledge
    input wire core_interrupt_ack_out,
    output reg interrupt_ack_out_n_q,
    // bus keepers
    input wire host_wide_mode_pin,
    output reg data_bus_keeper_en_q,
    output reg host_bus_keeper_en_q,
    output reg addr_bus_keeper_en_q
);
    //------------------------------------------------
    // state encodings
    //------------------------------------------------
    localparam ST_IDLE = 3'h0; // no access
    localparam ST_SWITCH = 3'h1; // bank switch, strobe withheld
    localparam ST_START = 3'h2; // consecutive-mode starting cycle
    localparam ST_WAIT = 3'h3; // counting wait states
    localparam ST_READY = 3'h4; // held by external ready
    localparam ST_TRAIL = 3'h5; // consecutive-mode trailing cycle
    // ready is entered directly when no waits are owed

    //------------------------------------------------
    // registers
    //------------------------------------------------
    reg [15:0] ranges_q; // wait_state_ranges
    reg [15:0] bank_q; // bank_switch_control
    reg mult_q; // wait_multiplier
    reg [2:0] state_q;
    reg [3:0] wcnt_q; // wait cycles left
    reg last_msb_q; // address top bit of last program or data access
    reg last_prog_q; // last program or data access was program space
    reg trail_q; // trailing cycle still owed
    wire [3:0] waits; // waits for current request
    wire div_rise; // output clock rising edge marker
    wire div_clk;

    // read-data decode used by the port
    function [15:0] rd_mux;
        input [15:0] a;
        input [15:0] r;
        input [15:0] b;
        input m;
        begin
            case (a)
                `EBWB_ADDR_RANGES: rd_mux = r;
                `EBWB_ADDR_BANK: rd_mux = b;
                `EBWB_ADDR_WCTRL: rd_mux = {15'h0000, m};
                default: rd_mux = 16'h0000; // unmapped reads as zero
            endcase
        end
    endfunction

    // first strobe state: a zero count skips the wait state entirely
    function [2:0] strobe_state;
        input [3:0] w;
        begin
            if (w == 4'h0)
                strobe_state = ST_READY;
            else
                strobe_state = ST_WAIT;
        end
    endfunction

    // write decode shared by the three registers
    function reg_hit;
        input w;
        input [15:0] a;
        input [15:0] t;
        begin
            reg_hit = w && (a == t);
        end
    endfunction

    //------------------------------------------------
    // submodules
    //------------------------------------------------
    // wait count is combinational from the live request
    ebwb_wait_count u_wc
    (
        .ranges(ranges_q),
        .mult(mult_q),
        .space(acc_space),
        .addr(acc_addr),
        .waits(waits)
    );

    // divider free-runs; its rise marks output clock edges
    ebwb_clkdiv u_div
    (
        .clk(clk),
        .resetn(resetn),
        .div(bank_q[`EBWB_DIV_LSB +: 2]),
        .clk_out_q(div_clk),
        .rise_q(div_rise)
    );

    //------------------------------------------------
    // register writes
    //------------------------------------------------
    // writes land at the edge, reads show one cycle later
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            ranges_q <= `EBWB_RANGES_RESET;
            bank_q <= `EBWB_BANK_RESET;
            mult_q <= 1'b0;
            reg_rdata_q <= 16'h0000;
        end
        else
        begin
            if (reg_hit(reg_wr, reg_addr, `EBWB_ADDR_RANGES))
                ranges_q <= reg_wdata;
            // reserved bank bits stay zero
            if (reg_hit(reg_wr, reg_addr, `EBWB_ADDR_BANK))
                bank_q <= reg_wdata & `EBWB_BANK_WMASK;
            // only bit 0 takes a write; upper bits are not stored at all
            if (reg_hit(reg_wr, reg_addr, `EBWB_ADDR_WCTRL))
                mult_q <= reg_wdata[`EBWB_MULT_BIT];
            // read data follows the address of the previous cycle
            reg_rdata_q <= rd_mux(reg_addr, ranges_q, bank_q, mult_q);
        end
    end

    //------------------------------------------------
    // pin outputs
    //------------------------------------------------
    // pins are registered once more so every output leaves a flop
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            clock_output_pin_q <= 1'b0;
            interrupt_ack_out_n_q <= 1'b1;
            data_bus_keeper_en_q <= 1'b0;
            host_bus_keeper_en_q <= 1'b0;
            addr_bus_keeper_en_q <= 1'b0;
        end
        else
        begin
            clock_output_pin_q <= div_clk;
            // suppress holds the acknowledge pin inactive
            interrupt_ack_out_n_q <= ~(core_interrupt_ack_out & ~bank_q[`EBWB_ACKOFF_BIT]);
            data_bus_keeper_en_q <= bank_q[`EBWB_BH_BIT];
            host_bus_keeper_en_q <= bank_q[`EBWB_HBH_BIT] | host_wide_mode_pin;
            addr_bus_keeper_en_q <= bank_q[`EBWB_HBH_BIT] & host_wide_mode_pin;
        end
    end

    //------------------------------------------------
    // access sequencer
    //------------------------------------------------
    // bank test: top bit of a 32K bank differs, or read switches program/data
    // limitation: writes also pay the crossing cycle; slower but always safe
    wire req_prog = (acc_space == `EBWB_SP_PROG);
    wire bank_cross = (acc_space != `EBWB_SP_IO) &&
                      ((acc_addr[15] != last_msb_q) || (acc_read && (req_prog != last_prog_q)));
    wire consecutive_bank_mode = bank_q[`EBWB_CONSECUTIVE_BANK_MODE_BIT];

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            state_q <= ST_IDLE;
            wcnt_q <= 4'h0;
            last_msb_q <= 1'b0;
            last_prog_q <= 1'b0;
            trail_q <= 1'b0;
            acc_busy_q <= 1'b0;
            acc_done_q <= 1'b0;
            memory_strobe_n_q <= 1'b1;
            ext_addr_q <= 23'h000000;
        end
        else
        begin
            acc_done_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (acc_req)
                    begin
                        acc_busy_q <= 1'b1;
                        ext_addr_q <= acc_addr;
                        wcnt_q <= waits;
                        trail_q <= consecutive_bank_mode && acc_read;
                        // bank bit tracks program and data only
                        if (acc_space != `EBWB_SP_IO)
                        begin
                            last_msb_q <= acc_addr[15];
                            last_prog_q <= req_prog;
                        end
                        if (consecutive_bank_mode && acc_read)
                            state_q <= ST_START;
                        else if (bank_cross)
                            state_q <= ST_SWITCH;
                        else
                        begin
                            memory_strobe_n_q <= 1'b0;
                            state_q <= strobe_state(waits);
                        end
                    end
                end
                ST_SWITCH, ST_START:
                begin
                    // strobe withheld one output clock while address settles
                    // the consecutive-mode start cycle shares this wait
                    if (div_rise)
                    begin
                        memory_strobe_n_q <= 1'b0;
                        state_q <= strobe_state(wcnt_q);
                    end
                end
                ST_WAIT:
                begin
                    // the last owed cycle is spent here, then ready follows
                    if (wcnt_q > 4'h1)
                        wcnt_q <= wcnt_q - 4'h1;
                    else
                        state_q <= ST_READY;
                end
                ST_READY:
                begin
                    // slow devices stretch further through ready
                    if (ext_ready)
                    begin
                        memory_strobe_n_q <= 1'b1;
                        if (trail_q)
                            state_q <= ST_TRAIL;
                        else
                        begin
                            acc_busy_q <= 1'b0;
                            acc_done_q <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_TRAIL:
                begin
                    // trailing cycle keeps the bus quiet before the next read
                    if (div_rise)
                    begin
                        acc_busy_q <= 1'b0;
                        acc_done_q <= 1'b1;
                        trail_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                // unused codes fall back to idle
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule // ebwb_ctrl
`default_nettype wire

// *** ebwb_defines.vh ***
`ifndef EBWB_DEFINES_VH
`define EBWB_DEFINES_VH
// register indices (word addresses on the core register port)
`define EBWB_ADDR_RANGES 16'h0028
`define EBWB_ADDR_BANK 16'h0029
`define EBWB_ADDR_WCTRL 16'h002b
// wait_state_ranges fields
`define EBWB_XPA_BIT 15
`define EBWB_IO_LSB 12
`define EBWB_DHI_LSB 9
`define EBWB_DLO_LSB 6
`define EBWB_PHI_LSB 3
`define EBWB_PLO_LSB 0
`define EBWB_RANGES_RESET 16'h7fff
// bank_switch_control fields
`define EBWB_CONSECUTIVE_BANK_MODE_BIT 15
`define EBWB_DIV_LSB 13
`define EBWB_ACKOFF_BIT 12
`define EBWB_HBH_BIT 2
`define EBWB_BH_BIT 1
`define EBWB_BANK_RESET 16'h7000
`define EBWB_BANK_WMASK 16'hf006
// wait_state_control fields
`define EBWB_MULT_BIT 0
// access space codes
`define EBWB_SP_PROG 2'h0
`define EBWB_SP_DATA 2'h1
`define EBWB_SP_IO 2'h2
`endif

// *** ebwb_clkdiv.v ***
`timescale 1ns/1ps
`default_nettype none
// clock output divider: output clock = clk / (div + 1), clk / 2 for div 0
module ebwb_clkdiv
(
    // clock and reset
    input wire clk,
    input wire resetn,
    // control
    input wire [1:0] div,
    // output
    output reg clk_out_q,
    output reg rise_q
);
    reg [1:0] cnt_q; // phase counter
    reg [1:0] cnt_d;
    always @*
    begin
        cnt_d = (cnt_q >= div) ? 2'h0 : cnt_q + 2'h1;
    end
    // high for first half of period; divide by 1 toggles each cycle at half rate, with rise each cycle
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            cnt_q <= 2'h0;
            clk_out_q <= 1'b0;
            rise_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            clk_out_q <= (div == 2'h0) ? ~clk_out_q : (cnt_d <= (div >> 1));
            rise_q <= (cnt_d == 2'h0);
        end
    end
endmodule // ebwb_clkdiv
`default_nettype wire

// *** ebwb_wait_count.v ***
`timescale 1ns/1ps
`default_nettype none
`include "ebwb_defines.vh"
// selects the base wait count for an access and applies the multiplier
module ebwb_wait_count
(
    // configuration
    input wire [15:0] ranges,
    input wire mult,
    // access
    input wire [1:0] space,
    input wire [22:0] addr,
    // result
    output reg [3:0] waits
);
    reg [2:0] base;
    always @*
    begin
        case (space)
            `EBWB_SP_IO: base = ranges[`EBWB_IO_LSB +: 3];
            `EBWB_SP_DATA: base = addr[15] ? ranges[`EBWB_DHI_LSB +: 3] : ranges[`EBWB_DLO_LSB +: 3];
            default:
            begin
                // program space: xpa picks page-half or 4M-half mapping
                if (ranges[`EBWB_XPA_BIT] ? addr[22] : addr[15])
                    base = ranges[`EBWB_PHI_LSB +: 3];
                else
                    base = ranges[`EBWB_PLO_LSB +: 3];
            end
        endcase
        waits = mult ? {base, 1'b0} : {1'b0, base};
    end
endmodule // ebwb_wait_count
`default_nettype wire

// *** ebwb_ctrl_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ebwb_defines.vh"
module ebwb_ctrl_chk
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic reg_wr,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata_q,
    // access and bus
    input wire logic acc_req,
    input wire logic acc_busy_q,
    input wire logic acc_done_q,
    input wire logic ext_ready,
    input wire logic memory_strobe_n_q,
    // acknowledge and keepers
    input wire logic interrupt_ack_out_n_q,
    input wire logic host_wide_mode_pin,
    input wire logic data_bus_keeper_en_q,
    input wire logic host_bus_keeper_en_q,
    input wire logic addr_bus_keeper_en_q
);
    // ------------------------------------------------
    // shadow of bank control bits, as the core writes them
    // ------------------------------------------------
    logic sup_q, hbh_q, bh_q;
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            sup_q <= 1'b1;
            hbh_q <= 1'b0;
            bh_q <= 1'b0;
        end
        else if (reg_wr && reg_addr == `EBWB_ADDR_BANK)
        begin
            sup_q <= reg_wdata[12];
            hbh_q <= reg_wdata[2];
            bh_q <= reg_wdata[1];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // named steps of one access
    sequence acc_start; acc_req && !acc_busy_q; endsequence
    sequence acc_finish; acc_done_q && memory_strobe_n_q && !acc_busy_q; endsequence
    // one- or two-deep stability: outputs are registered from the register
    strobe_busy_a: assert property (!memory_strobe_n_q |-> acc_busy_q) else $error("strobe outside access");
    start_busy_a: assert property (acc_start |=> acc_busy_q) else $error("access not taken");
    acc_bound_a: assert property (acc_start |-> ##[2:60] acc_finish) else $error("access never ends");
    done_pulse_a: assert property (acc_done_q |=> !acc_done_q) else $error("done not a pulse");
    hold_strobe_a: assert property (!memory_strobe_n_q && !ext_ready |=> !memory_strobe_n_q) else $error("strobe early");
    wctrl_rsvd_a: assert property (reg_addr == `EBWB_ADDR_WCTRL |=> reg_rdata_q[15:1] == 15'h0) else $error("rsvd set");
    interrupt_ack_out_gate_a: assert property (sup_q && $past(sup_q) |-> interrupt_ack_out_n_q) else $error("ack not gated");
    data_keep_a: assert property (bh_q == $past(bh_q) && bh_q == $past(bh_q, 2)
        |-> data_bus_keeper_en_q == bh_q) else $error("data keeper wrong");
    host_keep_a: assert property ($stable(hbh_q) && $stable(host_wide_mode_pin) && $past(hbh_q) == $past(hbh_q, 2)
        |-> host_bus_keeper_en_q == (hbh_q | host_wide_mode_pin)) else $error("host keeper wrong");
    addr_keep_a: assert property ($stable(hbh_q) && $stable(host_wide_mode_pin)
        |-> addr_bus_keeper_en_q == (hbh_q & host_wide_mode_pin)) else $error("addr keeper wrong");
endmodule // ebwb_ctrl_chk
`default_nettype wire

// *** ebwb_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// external memory: raises ready after a set count of strobe cycles
module ebwb_mem_model
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // bus side
    input wire logic strobe_n,
    input wire logic [3:0] stall,
    output logic ready
);
    logic [4:0] cnt_q; // strobe-low cycles seen
    always @(posedge clk)
    begin
        if (!resetn || strobe_n)
            cnt_q <= 5'h0;
        else
            cnt_q <= cnt_q + 5'h1;
    end
    // slow device holds ready low beyond the wait count
    assign ready = (cnt_q >= {1'b0, stall});
endmodule // ebwb_mem_model
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ebwb_defines.vh"
module testbench;
    logic clk, resetn, reg_wr, acc_req, acc_read, core_interrupt_ack_out, pin, ready, busy, done, strb_n, ck, ack_n, dk, hk, ak;
    logic [15:0] reg_addr, reg_wdata, rdata;
    logic [1:0] acc_space;
    logic [22:0] acc_addr, xaddr;
    logic [3:0] stall;
    int error_cnt = 0;
    int n_tests = 0;
    int lat, lo, r1, r2;
    logic pv;
    logic [45:0] row;
    // rows: ranges, multiplier, space, address, expected waits
    logic [45:0] rows [10] = '{
        {16'h5672, 1'h0, 2'h2, 23'h00ffff, 4'h5},
        {16'h5672, 1'h0, 2'h1, 23'h008000, 4'h3},
        {16'h5672, 1'h0, 2'h1, 23'h007fff, 4'h1},
        {16'h5672, 1'h0, 2'h0, 23'h018000, 4'h6},
        {16'h5672, 1'h0, 2'h0, 23'h7f7fff, 4'h2},
        {16'hd672, 1'h0, 2'h0, 23'h400000, 4'h6},
        {16'hd672, 1'h0, 2'h0, 23'h3fffff, 4'h2},
        {16'h5672, 1'h1, 2'h2, 23'h000000, 4'ha},
        {16'h7fff, 1'h1, 2'h1, 23'h000000, 4'he},
        {16'h0000, 1'h0, 2'h2, 23'h000000, 4'h0}};
    always #20 clk = ~clk;
    ebwb_ctrl DUT (.clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_q(rdata), .acc_req(acc_req), .acc_read(acc_read), .acc_space(acc_space), .acc_addr(acc_addr),
        .acc_busy_q(busy), .acc_done_q(done), .ext_ready(ready), .memory_strobe_n_q(strb_n), .ext_addr_q(xaddr),
        .clock_output_pin_q(ck), .core_interrupt_ack_out(core_interrupt_ack_out), .interrupt_ack_out_n_q(ack_n), .host_wide_mode_pin(pin),
        .data_bus_keeper_en_q(dk), .host_bus_keeper_en_q(hk), .addr_bus_keeper_en_q(ak));
    ebwb_mem_model mem (.clk(clk), .resetn(resetn), .strobe_n(strb_n), .stall(stall), .ready(ready));
    task tally_and_finish;
        if (error_cnt == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [22:0] e, input logic [22:0] g);
        n_tests++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task rd(input logic [15:0] a, input logic [15:0] e);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        chk("rdata", e, rdata);
    endtask
    // one access; lat counts cycles to done, lo strobe-low cycles
    task acc(input logic [1:0] sp, input logic [22:0] a, input logic r);
        @(negedge clk);
        {acc_space, acc_addr, acc_read, acc_req} = {sp, a, r, 1'b1};
        @(negedge clk);
        acc_req = 1'b0;
        lat = 1;
        lo = (strb_n === 1'b0);
        while (done !== 1'b1 && lat < 100)
        begin
            @(negedge clk);
            lat++;
            lo += (strb_n === 1'b0);
        end
        chk("ext addr", a, xaddr);
        if (lat >= 100)
        begin
            error_cnt++;
            tally_and_finish;
        end
    endtask
    initial
    begin
        {clk, resetn, reg_wr, reg_addr, reg_wdata, acc_req, acc_read, acc_space, acc_addr} = '0;
        {core_interrupt_ack_out, pin, stall} = '0;
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        rd(16'h0028, 16'h7fff);
        rd(16'h0029, 16'h7000);
        chk("keep", 16'h0, {13'h0, ak, hk, dk});
        acc(2'h2, 23'h0, 1'b0);
        chk("waits", 16'h8, 16'(lo));
        wr(16'h002b, 16'hffff);
        rd(16'h002b, 16'h0001);
        rd(16'h002a, 16'h0000);
        foreach (rows[i])
        begin
            row = rows[i];
            wr(16'h0028, row[45:30]);
            wr(16'h002b, {15'h0, row[29]});
            rd(16'h0028, row[45:30]);
            acc(row[28:27], row[26:4], 1'b0);
            chk("waits", {12'h0, row[3:0]} + 16'h1, 16'(lo));
        end
        stall = 4'h5;
        acc(2'h2, 23'h0, 1'b0);
        chk("stall", 16'h6, 16'(lo));
        stall = 4'h0;
        acc(2'h1, 23'h0, 1'b1);
        acc(2'h1, 23'h0, 1'b1);
        chk("same bank", 16'h2, 16'(lat));
        acc(2'h1, 23'h8000, 1'b1);
        chk("cross", 16'h1, {15'h0, lat > 2});
        wr(16'h0029, 16'hf000);
        acc(2'h1, 23'h8000, 1'b1);
        chk("consecutive_bank_mode", 16'h1, {15'h0, lat > 2});
        for (int c = 0; c < 4; c++)
        begin
            wr(16'h0029, {1'b0, c[1:0], 13'h1000});
            r1 = -1;
            r2 = -1;
            pv = ck;
            for (int k = 0; k < 20; k++)
            begin
                @(negedge clk);
                if (!pv && ck === 1'b1)
                begin
                    if (r1 < 0)
                        r1 = k;
                    else if (r2 < 0)
                        r2 = k;
                end
                pv = ck;
            end
            // code 00 cannot pass the clock through a flop, so it toggles at half rate
            chk("period", 16'((c == 0) ? 2 : c + 1), 16'(r2 - r1));
        end
        core_interrupt_ack_out = 1'b1;
        wr(16'h0029, 16'h7000);
        repeat (3) @(negedge clk);
        chk("ack", 16'h1, {15'h0, ack_n});
        wr(16'h0029, 16'h6000);
        repeat (3) @(negedge clk);
        chk("ack", 16'h0, {15'h0, ack_n});
        for (int j = 0; j < 8; j++)
        begin
            pin = j[2];
            wr(16'h0029, {13'h0e00, j[1:0], 1'b0});
            repeat (3) @(negedge clk);
            chk("keep", {13'h0, j[1] & j[2], j[1] | j[2], j[0]}, {13'h0, ak, hk, dk});
        end
        // second reset in mid-run brings every register back
        pin = 1'b0;
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        rd(16'h0028, 16'h7fff);
        rd(16'h0029, 16'h7000);
        rd(16'h002b, 16'h0000);
        chk("keep", 16'h0, {13'h0, ak, hk, dk});
        tally_and_finish;
    end
endmodule // testbench
bind ebwb_ctrl ebwb_ctrl_chk u_chk (.clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .acc_req(acc_req), .acc_busy_q(acc_busy_q),
    .acc_done_q(acc_done_q), .ext_ready(ext_ready), .memory_strobe_n_q(memory_strobe_n_q),
    .interrupt_ack_out_n_q(interrupt_ack_out_n_q), .host_wide_mode_pin(host_wide_mode_pin),
    .data_bus_keeper_en_q(data_bus_keeper_en_q), .host_bus_keeper_en_q(host_bus_keeper_en_q),
    .addr_bus_keeper_en_q(addr_bus_keeper_en_q));
`default_nettype wire
